//--- hw/isr_script_ram.sv
// Purpose: Internal script RAM with bus target port and engine fetch port.
// Assumes: Target decode is presented as a request pulse from the bus interface logic.
// Notes: Engine fetches have priority; a pending target access waits its wait states.
//   A refused target request gets no hit and leaves no trace.
`timescale 1ns/100ps
`include "isr_consts.svh"
module isr_script_ram #(
  parameter int WORDS = `ISR_RAM_WORDS,
  parameter int AW = `ISR_ADDR_BITS
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ram_enable_strap,
  input wire logic [31:0] ram_base_wdata,
  input wire logic ram_base_we,
  input wire logic [7:0] chip_test_control_two,
  input wire logic [31:0] scratch_pad_b_in,
  input wire logic tgt_req,
  input wire isr_pkg::isr_tgt_req_t tgt_cmd,
  input wire logic fetch_req,
  input wire isr_pkg::isr_fetch_req_t fetch_cmd,
  input wire logic other_req,
  input wire logic [31:0] other_addr,
  output logic tgt_hit,
  output logic tgt_ack,
  output logic [31:0] tgt_rdata,
  output logic fetch_ack,
  output logic [31:0] fetch_rdata,
  output logic fetch_use_bus,
  output logic other_use_bus,
  output logic [31:0] ram_base,
  output logic [31:0] scratch_pad_b,
  output logic ram_enabled
);
  // Strap capture, base, sequencer, response and routing registers.
  logic strap_s1_reg;
  logic strap_s2_reg;
  logic strap_taken_reg;
  logic ram_en_reg;
  logic [31:0] base_reg;
  isr_pkg::isr_state_t state_reg;
  isr_pkg::isr_state_t state_next;
  logic [2:0] wait_reg;
  logic [2:0] wait_next;
  isr_pkg::isr_tgt_req_t hold_reg;
  logic fetch_pend_reg;
  logic tgt_hit_reg;
  logic tgt_ack_reg;
  logic [31:0] tgt_rdata_reg;
  logic fetch_ack_reg;
  logic [31:0] fetch_rdata_reg;
  logic fetch_bus_reg;
  logic other_bus_reg;
  logic [31:0] scratch_reg;
  logic [31:0] rd_data;

  // Address decode against the relocatable base window.
  // The mask keeps the twelve offset bits out of the compare.
  wire logic tgt_in_ram = ram_en_reg &&
    ((tgt_cmd.addr & `ISR_BASE_MASK) == base_reg); // [RQ5]
  wire logic fetch_in_ram = ram_en_reg &&
    ((fetch_cmd.addr & `ISR_BASE_MASK) == base_reg);
  // Other device accesses are not decoded at all: even a window hit goes out on the bus.
  wire logic fetch_local = fetch_req && fetch_in_ram; // [RQ2]
  wire logic tgt_start = tgt_req && tgt_in_ram && (state_reg == isr_pkg::ISR_IDLE);

  // Sequencer phase decodes, shared by the array write enable and the response registers.
  wire logic in_wait = (state_reg == isr_pkg::ISR_WAIT);
  wire logic in_done = (state_reg == isr_pkg::ISR_DONE);
  wire logic wait_over = in_wait && (wait_reg == 3'h0);
  wire logic do_write = wait_over && hold_reg.write && !fetch_local; // [RQ7]
  wire logic [AW-1:0] rd_index = fetch_local ? fetch_cmd.addr[AW+1:2] : hold_reg.addr[AW+1:2];
  wire logic test_show_base = chip_test_control_two[`ISR_TEST_BASE_BIT];

  // One store serves both ports; engine and target share its single read address.
  isr_ram_array #(
    .WORDS(WORDS),
    .AW(AW)
  ) u_array (
    .core_clk(core_clk),
    .wr_en(do_write),
    .wr_addr(hold_reg.addr[AW+1:2]),
    .wr_data(hold_reg.wdata),
    .wr_be(hold_reg.byte_en),
    .rd_addr(rd_index),
    .rd_data(rd_data)
  );

  // Strap is synchronised, then caught once after reset release.
  // Sampling once keeps a strap that moves later from switching the RAM mid-script.
  always_ff @(posedge core_clk) begin
    strap_s1_reg <= ram_enable_strap;
    strap_s2_reg <= strap_s1_reg;
    if (reset) begin
      strap_taken_reg <= 1'b0;
      ram_en_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      ram_en_reg <= strap_s2_reg; // [RQ4]
    end
  end

  // Base register acts like an expansion ROM base: only the upper bits are writable.
  // The low twelve bits read as zero, which sizes the window at 4 KB.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      base_reg <= `ISR_BASE_RESET;
    end else if (ram_base_we) begin
      base_reg <= ram_base_wdata & `ISR_BASE_MASK; // [RQ5]
    end
  end

  // Target sequence: count down wait states, then complete; fetches may stretch it.
  // Stalling the target rather than the engine keeps script timing exact.
  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    unique case (state_reg)
      isr_pkg::ISR_IDLE: begin
        if (tgt_start) begin
          state_next = isr_pkg::ISR_WAIT;
          wait_next = 3'(`ISR_RAM_WAIT - 1); // [RQ8]
        end
      end
      isr_pkg::ISR_WAIT: begin
        if (fetch_local) begin
          wait_next = wait_reg; // Engine fetch holds the port this cycle.
        end else if (wait_reg == 3'h0) begin
          state_next = isr_pkg::ISR_DONE;
        end else begin
          wait_next = wait_reg - 3'h1;
        end
      end
      isr_pkg::ISR_DONE: begin
        state_next = isr_pkg::ISR_IDLE;
      end
      default: begin
        state_next = isr_pkg::ISR_IDLE;
      end
    endcase
  end

  // Sequencer and captured request.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= isr_pkg::ISR_IDLE;
      wait_reg <= 3'h0;
      hold_reg <= '0;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      if (tgt_start) begin
        hold_reg <= tgt_cmd;
      end
    end
  end

  // Read data lands one cycle after the array is addressed, so the ack trails DONE.
  // A hit marks an accepted access only; a request refused while busy gets none,
  // so a master never waits on an ack that will not come.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tgt_hit_reg <= 1'b0;
      tgt_ack_reg <= 1'b0;
      tgt_rdata_reg <= 32'h0;
    end else begin
      tgt_hit_reg <= tgt_start; // [RQ8]
      tgt_ack_reg <= in_done; // [RQ8]
      if (in_done && !hold_reg.write) begin
        tgt_rdata_reg <= rd_data;
      end
    end
  end

  // Local fetch response: the word is taken from the array one cycle after its address.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fetch_pend_reg <= 1'b0;
      fetch_ack_reg <= 1'b0;
      fetch_rdata_reg <= 32'h0;
    end else begin
      fetch_pend_reg <= fetch_local; // [RQ2]
      fetch_ack_reg <= fetch_pend_reg;
      if (fetch_pend_reg) begin
        fetch_rdata_reg <= rd_data;
      end
    end
  end

  // Bus routing flags: engine fetch misses, and every other device access.
  // Other accesses go out even when they hit the window, which costs bus time
  // but keeps their ordering with external writers simple.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fetch_bus_reg <= 1'b0;
      other_bus_reg <= 1'b0;
    end else begin
      fetch_bus_reg <= fetch_req && !fetch_in_ram; // [RQ2]
      other_bus_reg <= other_req; // [RQ3]
    end
  end

  // Scratch pad B shows the base while the test bit is set.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      scratch_reg <= 32'h0;
    end else begin
      scratch_reg <= test_show_base ? base_reg : scratch_pad_b_in; // [RQ6]
    end
  end

  // Every output is the flop behind it, with no logic after the register.
  assign tgt_hit = tgt_hit_reg;
  assign tgt_ack = tgt_ack_reg;
  assign tgt_rdata = tgt_rdata_reg;
  assign fetch_ack = fetch_ack_reg;
  assign fetch_rdata = fetch_rdata_reg;
  assign fetch_use_bus = fetch_bus_reg;
  assign other_use_bus = other_bus_reg;
  assign ram_base = base_reg;
  assign scratch_pad_b = scratch_reg;
  assign ram_enabled = ram_en_reg;
endmodule : isr_script_ram

//--- hw/isr_consts.svh
// Purpose: Constants for the internal script RAM block.
// Assumes: Core clock at 40 MHz, synchronous active-high reset.
// Notes on behaviour
// RQ1: Provide 4 KB of general RAM, 1024 words of 32 bits.
// RQ2: Script engine instruction and table-indirect fetches are served internally, no bus cycle.
// RQ3: Other device-initiated RAM accesses go out as ordinary bus master transactions.
// RQ4: RAM enabled unless the enable strap reads low at power-up.
// RQ5: RAM decoded at a relocatable base held in a configuration base register.
// RQ6: With test control bit 3 set, scratch pad B shows the RAM base.
// RQ7: Byte-granular target accesses accepted from any bus master.
// RQ8: Target accesses use register slave sequence but 3 wait states, not 5.
// RQ9: Target writes update only bytes whose byte enables are asserted.
`ifndef ISR_CONSTS_SVH
`define ISR_CONSTS_SVH
`define ISR_RAM_WORDS 1024
`define ISR_ADDR_BITS 10
`define ISR_RAM_WAIT 3
`define ISR_REG_WAIT 5
`define ISR_TEST_BASE_BIT 3
`define ISR_BASE_MASK 32'hfffff000
`define ISR_BASE_RESET 32'h00000000
`endif

//--- hw/isr_pkg.sv
// Purpose: Types shared by the internal script RAM files.
// Assumes: The constants header is included by each user.
// Notes: Structs carry a target request and an engine fetch.
package isr_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] byte_en;
    logic write;
  } isr_tgt_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic table_indirect;
  } isr_fetch_req_t;

  typedef enum logic [1:0] {
    ISR_IDLE = 2'b00,
    ISR_WAIT = 2'b01,
    ISR_DONE = 2'b10
  } isr_state_t;
endpackage : isr_pkg

//--- hw/isr_ram_array.sv
// Purpose: Flip-flop word store with per-byte write lanes.
// Assumes: One write and one read port per clock.
// Notes: Read data is registered, one cycle after the address.
`timescale 1ns/100ps
module isr_ram_array #(
  parameter int WORDS = 1024,
  parameter int AW = 10
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_be,
  input wire logic [AW-1:0] rd_addr,
  output logic [31:0] rd_data
);
  logic [31:0] mem_reg [WORDS]; // [RQ1]

  // Each lane is written only when its enable is set; others keep their value.
  always_ff @(posedge core_clk) begin
    for (int b = 0; b < 4; b++) begin
      if (wr_en && wr_be[b]) begin
        mem_reg[wr_addr][8*b +: 8] <= wr_data[8*b +: 8]; // [RQ9]
      end
    end
    rd_data <= mem_reg[rd_addr];
  end
endmodule : isr_ram_array

//--- tb/isr_props.sv
// Purpose: Port checks for the script RAM.
// Assumes: The base register is held steady around fetches.
// Notes: Bound at the foot of this file.
`timescale 1ns/100ps
`include "isr_consts.svh"
module isr_props (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tgt_hit,
  input wire logic tgt_ack,
  input wire logic fetch_req,
  input wire isr_pkg::isr_fetch_req_t fetch_cmd,
  input wire logic fetch_ack,
  input wire logic fetch_use_bus,
  input wire logic other_req,
  input wire logic other_use_bus,
  input wire logic [31:0] ram_base,
  input wire logic ram_enabled
);
  // A disabled RAM matches no fetch, so every fetch then goes out.
  wire logic f_in = ram_enabled && (fetch_cmd.addr & `ISR_BASE_MASK) == ram_base;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence calm; !fetch_req [*4]; endsequence
  sequence loc_ok; !fetch_use_bus ##1 fetch_ack; endsequence
  ack_late_a: assert property (tgt_hit ##0 calm |=> tgt_ack) else $error("ack late");
  ack_early_a: assert property (tgt_hit |=> !tgt_ack [*3]) else $error("ack early");
  hit_busy_a: assert property (tgt_hit |=> !tgt_hit [*4]) else $error("hit busy");
  ack_once_a: assert property (tgt_ack |=> !tgt_ack) else $error("ack long");
  fetch_local_a: assert property (fetch_req && f_in |=> loc_ok) else $error("local");
  fetch_bus_a: assert property (fetch_req && !f_in |=> fetch_use_bus) else $error("bus");
  other_bus_a: assert property (other_req |=> other_use_bus) else $error("other");
  strap_hold_a: assert property (!$past(reset) && !$past(reset, 2) |-> $stable(ram_enabled))
    else $error("enable moved");
endmodule : isr_props
bind isr_script_ram isr_props u_props (
  .core_clk(core_clk),
  .reset(reset),
  .tgt_hit(tgt_hit),
  .tgt_ack(tgt_ack),
  .fetch_req(fetch_req),
  .fetch_cmd(fetch_cmd),
  .fetch_ack(fetch_ack),
  .fetch_use_bus(fetch_use_bus),
  .other_req(other_req),
  .other_use_bus(other_use_bus),
  .ram_base(ram_base),
  .ram_enabled(ram_enabled)
);

//--- tb/isr_master_model.sv
// Purpose: Bus master model for target accesses.
// Assumes: The bench starts one access at a time.
// Notes: Released command fields are inverted, never left stale.
`timescale 1ns/100ps
module isr_master_model (
  input wire logic core_clk,
  input wire logic tgt_hit,
  input wire logic tgt_ack,
  input wire logic [31:0] tgt_rdata,
  output logic tgt_req,
  output isr_pkg::isr_tgt_req_t tgt_cmd
);
  initial {tgt_req, tgt_cmd} = '0;
  // One request pulse; a hit is timed up to the ack, a miss returns at once.
  task automatic access(input isr_pkg::isr_tgt_req_t c, output logic hit, output int n,
    output logic [31:0] rd);
    @(posedge core_clk);
    {tgt_req, tgt_cmd} <= {1'b1, c};
    @(posedge core_clk);
    {tgt_req, tgt_cmd} <= {1'b0, ~c};
    #1 hit = tgt_hit;
    for (n = 0; hit === 1'b1 && tgt_ack !== 1'b1 && n < 12; n++)
      @(posedge core_clk) #1;
    rd = tgt_rdata;
  endtask : access
endmodule : isr_master_model

//--- tb/testbench.sv
// Purpose: Self-checking bench for the script RAM.
// Assumes: The strap is steady through each reset.
// Notes: Data comes from a shift register seeded at 69.
`timescale 1ns/100ps
`include "isr_consts.svh"
module testbench;
  logic core_clk = 1'b0, reset = 1'b1, ram_enable_strap = 1'b1, ram_base_we = 1'b0;
  logic fetch_req = 1'b0, other_req = 1'b0, tgt_req, tgt_hit, tgt_ack, fetch_ack, hit;
  logic fetch_use_bus, other_use_bus, ram_enabled;
  logic [7:0] chip_test_control_two = 8'h00;
  logic [31:0] ram_base_wdata = 32'h0, scratch_pad_b_in = 32'h0, other_addr = 32'h0;
  logic [31:0] tgt_rdata, fetch_rdata, ram_base, scratch_pad_b, b, w, d, a, rd;
  logic [15:0] seed = 16'h0045;
  isr_pkg::isr_tgt_req_t tgt_cmd;
  isr_pkg::isr_fetch_req_t fetch_cmd = '0;
  int num_errors = 0, checks_done = 0, cyc = 0, n;
  isr_script_ram dut (
    .core_clk(core_clk),
    .reset(reset),
    .ram_enable_strap(ram_enable_strap),
    .ram_base_wdata(ram_base_wdata),
    .ram_base_we(ram_base_we),
    .chip_test_control_two(chip_test_control_two),
    .scratch_pad_b_in(scratch_pad_b_in),
    .tgt_req(tgt_req),
    .tgt_cmd(tgt_cmd),
    .fetch_req(fetch_req),
    .fetch_cmd(fetch_cmd),
    .other_req(other_req),
    .other_addr(other_addr),
    .tgt_hit(tgt_hit),
    .tgt_ack(tgt_ack),
    .tgt_rdata(tgt_rdata),
    .fetch_ack(fetch_ack),
    .fetch_rdata(fetch_rdata),
    .fetch_use_bus(fetch_use_bus),
    .other_use_bus(other_use_bus),
    .ram_base(ram_base),
    .scratch_pad_b(scratch_pad_b),
    .ram_enabled(ram_enabled)
  );
  isr_master_model mst (
    .core_clk(core_clk),
    .tgt_hit(tgt_hit),
    .tgt_ack(tgt_ack),
    .tgt_rdata(tgt_rdata),
    .tgt_req(tgt_req),
    .tgt_cmd(tgt_cmd)
  );
  // Clock, and a ceiling so that a hang still reaches the report.
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 3000) tally_and_finish();
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask : tick
  function automatic logic [31:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed, ~seed};
  endfunction : rnd
  // Expected word after a write through lanes e.
  function automatic logic [31:0] merge(input logic [31:0] o, v, input logic [3:0] e);
    for (int i = 0; i < 4; i++) o[8*i+:8] = e[i] ? v[8*i+:8] : o[8*i+:8];
    return o;
  endfunction : merge
  task automatic chk(input string s, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) num_errors++;
    if (g !== e) $display("[FAIL] %s exp %h got %h", s, e, g);
  endtask : chk
  task automatic tally_and_finish();
    if (cyc >= 3000) num_errors++;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic restart(input logic s);
    tick(1);
    {ram_enable_strap, reset} <= {s, 1'b1};
    tick(4);
    reset <= 1'b0;
    tick(3);
    #1 chk("ram_enabled", {31'h0, s}, {31'h0, ram_enabled});
  endtask : restart
  // A fetch and another access share the taken edge, so one wait checks both.
  task automatic fetch(input logic [31:0] x, input logic loc);
    tick(1);
    {fetch_req, other_req, other_addr, fetch_cmd} <= {2'b11, x, x, seed[0]};
    tick(1);
    {fetch_req, other_req} <= 2'b00;
    #1 chk("use_bus", {30'h0, !loc, 1'b1}, {30'h0, fetch_use_bus, other_use_bus});
    tick(1);
    #1 chk("fetch_ack", {31'h0, loc}, {31'h0, fetch_ack});
  endtask : fetch
  initial begin
    restart(1'b1);
    b = rnd() | 32'h00000fff;
    w = rnd();
    tick(1);
    {ram_base_we, ram_base_wdata, scratch_pad_b_in} <= {1'b1, b, w};
    chip_test_control_two <= 8'h08;
    tick(1);
    ram_base_we <= 1'b0;
    b = b & `ISR_BASE_MASK;
    tick(3);
    #1 chk("ram_base", b, ram_base);
    chk("scratch_pad_b", b, scratch_pad_b);
    tick(1);
    chip_test_control_two <= 8'hf7;
    tick(2);
    #1 chk("scratch_pad_b", w, scratch_pad_b);
    $display("test config done");
    for (int i = 0; i < 4; i++) begin
      w = rnd();
      d = rnd();
      a = b | {20'h0, i == 0 ? 10'h3ff : i == 1 ? 10'h000 : w[11:2], 2'b00};
      mst.access('{a, w, 4'hf, 1'b1}, hit, n, rd);
      chk("wait_cycles", 32'(`ISR_RAM_WAIT + 1), 32'(n));
      mst.access('{a, d, d[7:4], 1'b1}, hit, n, rd);
      mst.access('{a, ~w, 4'hf, 1'b0}, hit, n, rd);
      chk("read_data", merge(w, d, d[7:4]), rd);
      fetch(a, 1'b1);
      chk("fetch_rdata", merge(w, d, d[7:4]), fetch_rdata);
    end
    $display("test ram done");
    mst.access('{b ^ 32'h00001000, w, 4'hf, 1'b1}, hit, n, rd);
    chk("tgt_hit", 32'h0, {31'h0, hit});
    fetch(b ^ 32'h00001000, 1'b0);
    restart(1'b0);
    fetch(32'h0, 1'b0);
    $display("test bus done");
    tally_and_finish();
  end
endmodule : testbench
